//--- cfa_flash_crc.sv
// cfa_flash_crc: automatic flash crc sequencer, sector registers and bit-reverse byte
// assumes a one-cycle-latency flash read port and an external crc engine taking byte strobes
//
// Overview of operation
// R01: control write with enable starts flash crc; code also requires an idle sequencer and a nonzero sector count
// R02: complete flag low while running, high after
// R03: cpu halted during run; reads see one
// R04: start address is start sector times 512
// R05: sector count six bits, top bits zero
// R06: bit-reverse register mirrors last written byte
// R07: result init loads zeros or ones
// R08: flash bytes fed sequentially like manual input
`timescale 1ns/1ps
`default_nettype none
module cfa_flash_crc #(
  parameter int ADDR_W = 15 // flash byte address width
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register bus
  input wire cfa_pkg::cfa_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // cpu stall
  output logic cpu_halt,
  // flash read port
  output logic flash_rd,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  // crc engine feed
  output cfa_pkg::cfa_crc_byte_t crc_byte,
  output logic crc_init,
  output logic crc_init_ones
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CFA_IDLE, CFA_READ, CFA_FEED} cfa_state_t;
  cfa_state_t state_reg, state_next; // sequencer state
  logic [7:0] flip_reg; // bit_reverse_reg stores mirrored byte
  logic auto_en_reg; // auto_calc_enable
  logic [5:0] start_reg; // start_sector
  logic [5:0] count_reg; // sector_count
  logic [ADDR_W-1:0] addr_reg, addr_next; // running flash address
  logic [ADDR_W-1:0] end_reg; // last address of region
  logic [7:0] rdata_reg; // read data
  logic halt_reg; // cpu stall
  logic rd_reg; // flash read
  cfa_pkg::cfa_crc_byte_t byte_reg; // crc feed
  logic init_reg, init_ones_reg; // result init pulse
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_ctl = sfr_req.wr && sfr_req.addr == cfa_pkg::ADDR_CRC_CONTROL;
  wire wr_flip = sfr_req.wr && sfr_req.addr == cfa_pkg::ADDR_BIT_REVERSE;
  wire wr_auto = sfr_req.wr && sfr_req.addr == cfa_pkg::ADDR_AUTO_CONTROL;
  wire wr_cnt = sfr_req.wr && sfr_req.addr == cfa_pkg::ADDR_SECTOR_COUNT;
  wire running = state_reg != CFA_IDLE;
  // R01: start on control write
  wire start = wr_ctl && auto_en_reg && !running && count_reg != 6'h00;
  // R04: region base
  wire [ADDR_W-1:0] base_addr = ADDR_W'(start_reg) << cfa_pkg::PAGE_SHIFT;
  wire [ADDR_W:0] end_wide = ({1'b0, base_addr} + ((ADDR_W+1)'(count_reg) << cfa_pkg::PAGE_SHIFT)) - 1'b1;
  // R06: mirror on write
  wire [7:0] flip_in;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flip
      assign flip_in[gi] = sfr_req.wdata[7-gi];
    end
  endgenerate
  // R02: done flag low while running
  wire [7:0] auto_rd = {auto_en_reg, !running, start_reg};
  // R05: top bits read zero
  wire [7:0] rd_mux = (sfr_req.addr == cfa_pkg::ADDR_BIT_REVERSE) ? flip_reg :
                      (sfr_req.addr == cfa_pkg::ADDR_AUTO_CONTROL) ? auto_rd :
                      (sfr_req.addr == cfa_pkg::ADDR_SECTOR_COUNT) ? {2'b00, count_reg} : 8'h00;
  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    case (state_reg)
      CFA_IDLE:
      begin
        // idle waits for a start
        if (start)
        begin
          state_next = CFA_READ;
          addr_next = base_addr;
        end
      end
      // R08: sequential read
      CFA_READ: state_next = CFA_FEED;
      CFA_FEED:
      begin
        // feed byte, then next address or finish
        if (addr_reg == end_reg)
          state_next = CFA_IDLE;
        else
        begin
          state_next = CFA_READ;
          addr_next = addr_reg + 1'b1;
        end
      end
      default: state_next = CFA_IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= CFA_IDLE;
      addr_reg <= '0;
      end_reg <= '0;
      flip_reg <= cfa_pkg::RST_BIT_REVERSE;
      auto_en_reg <= cfa_pkg::RST_AUTO_CONTROL[cfa_pkg::AUTO_EN_BIT];
      start_reg <= cfa_pkg::RST_AUTO_CONTROL[cfa_pkg::FIELD_MSB:0];
      count_reg <= cfa_pkg::RST_SECTOR_COUNT[cfa_pkg::FIELD_MSB:0];
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      if (start)
        end_reg <= end_wide[ADDR_W-1:0];
      if (wr_flip)
        flip_reg <= flip_in;
      if (wr_auto)
      begin
        auto_en_reg <= sfr_req.wdata[cfa_pkg::AUTO_EN_BIT];
        start_reg <= sfr_req.wdata[cfa_pkg::FIELD_MSB:0];
      end
      // R05: only low six bits kept
      if (wr_cnt)
        count_reg <= sfr_req.wdata[cfa_pkg::FIELD_MSB:0];
    end
  end
  // output flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= 8'h00;
      halt_reg <= 1'b0;
      rd_reg <= 1'b0;
      byte_reg <= '0;
      init_reg <= 1'b0;
      init_ones_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rd_mux;
      // R03: halt cpu
      halt_reg <= state_next != CFA_IDLE;
      rd_reg <= state_next == CFA_READ;
      // R08: byte like manual input
      byte_reg.valid <= state_reg == CFA_FEED;
      byte_reg.data <= flash_rdata;
      // R07: init select
      init_reg <= wr_ctl && sfr_req.wdata[cfa_pkg::INIT_BIT];
      init_ones_reg <= sfr_req.wdata[cfa_pkg::INIT_SEL_BIT];
    end
  end
  assign sfr_rdata = rdata_reg;
  assign cpu_halt = halt_reg;
  assign flash_rd = rd_reg;
  assign flash_addr = addr_reg;
  assign crc_byte = byte_reg;
  assign crc_init = init_reg;
  assign crc_init_ones = init_ones_reg;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // start loads the region base into the read address
  property p_start;
    @(posedge ref_clk) disable iff (!rstn) start |=> state_reg == CFA_READ && addr_reg == $past(base_addr);
  endproperty
  a_start: assert property (p_start) else $error("auto crc did not start"); // R01
  // done flag as read over the bus is low while running
  property p_done;
    @(posedge ref_clk) disable iff (!rstn)
      (running && sfr_req.addr == cfa_pkg::ADDR_AUTO_CONTROL) |=> !sfr_rdata[cfa_pkg::AUTO_DONE_BIT];
  endproperty
  a_done: assert property (p_done) else $error("done flag high while running"); // R02
  // last byte fed releases the stall in the same cycle
  property p_end;
    @(posedge ref_clk) disable iff (!rstn)
      (state_reg == CFA_FEED && addr_reg == end_reg) |=> !cpu_halt && crc_byte.valid;
  endproperty
  a_end: assert property (p_end) else $error("stall not released after last byte"); // R02
  property p_halt;
    @(posedge ref_clk) disable iff (!rstn) running |-> cpu_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("cpu not halted"); // R03
  property p_cnt;
    @(posedge ref_clk) disable iff (!rstn) wr_cnt |=> count_reg == $past(sfr_req.wdata[5:0]);
  endproperty
  a_cnt: assert property (p_cnt) else $error("sector count wrong"); // R05
  property p_flip;
    @(posedge ref_clk) disable iff (!rstn) wr_flip |=> $past(sfr_req.wdata) ==
      {flip_reg[0], flip_reg[1], flip_reg[2], flip_reg[3], flip_reg[4], flip_reg[5], flip_reg[6], flip_reg[7]};
  endproperty
  a_flip: assert property (p_flip) else $error("bit reverse wrong"); // R06
  property p_init;
    @(posedge ref_clk) disable iff (!rstn) (wr_ctl && sfr_req.wdata[cfa_pkg::INIT_BIT]) |=>
      crc_init && crc_init_ones == $past(sfr_req.wdata[cfa_pkg::INIT_SEL_BIT]);
  endproperty
  a_init: assert property (p_init) else $error("init pulse missing"); // R07
  sequence s_read;
    state_reg == CFA_READ ##1 state_reg == CFA_FEED;
  endsequence
  property p_feed;
    @(posedge ref_clk) disable iff (!rstn) s_read |=> crc_byte.valid;
  endproperty
  a_feed: assert property (p_feed) else $error("byte not fed"); // R08
  property p_base;
    @(posedge ref_clk) disable iff (!rstn)
      start |=> flash_rd && flash_addr[8:0] == 9'h000 && (flash_addr >> cfa_pkg::PAGE_SHIFT) == $past(start_reg);
  endproperty
  a_base: assert property (p_base) else $error("start not sector aligned"); // R04
endmodule
`default_nettype wire

//--- cfa_pkg.sv
// cfa_pkg: constants and carrier types for the flash crc auto-calculation block
// assumes an 8-bit special-function-register bus on one clock
package cfa_pkg;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CRC_CONTROL = 8'h92; // crc_control_reg, lives in the manual datapath
  localparam logic [7:0] ADDR_BIT_REVERSE = 8'h95; // bit_reverse_reg
  localparam logic [7:0] ADDR_AUTO_CONTROL = 8'h96; // auto_control_reg
  localparam logic [7:0] ADDR_SECTOR_COUNT = 8'h97; // sector_count
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int AUTO_EN_BIT = 7; // auto_calc_enable
  localparam int AUTO_DONE_BIT = 6; // auto_calc_complete
  localparam int FIELD_MSB = 5; // start_sector and sector_count top bit
  localparam int INIT_BIT = 3; // result_init in crc_control_reg
  localparam int INIT_SEL_BIT = 2; // init_value_select in crc_control_reg
  localparam logic [7:0] RST_BIT_REVERSE = 8'h00;
  localparam logic [7:0] RST_AUTO_CONTROL = 8'h40;
  localparam logic [7:0] RST_SECTOR_COUNT = 8'h00;
  localparam int PAGE_SHIFT = 9; // 512-byte sectors
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
  } cfa_sfr_req_t;
  typedef struct packed
  {
    logic valid; // byte into crc engine
    logic [7:0] data; // the byte
  } cfa_crc_byte_t;
endpackage

//--- crc_flash_auto_and_bit_reverse_tb_top.sv
// testbench for the flash crc auto-calculation block
// assumes cfa_pkg and cfa_flash_crc compiled first
`timescale 1ns/1ps
`default_nettype none
module crc_flash_auto_and_bit_reverse_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} cfa_row_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cfa_pkg::cfa_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] flash_rdata = 8'h00;
  logic cpu_halt, flash_rd, crc_init, crc_init_ones;
  logic [14:0] flash_addr;
  logic [14:0] exp_a = 15'h0000;
  cfa_pkg::cfa_crc_byte_t crc_byte;
  int failures = 0;
  int checked = 0;
  int nbytes = 0;
  // write, then read back: address, data, expected
  cfa_row_t rows[6] = '{'{8'h95, 8'hC0, 8'h03}, '{8'h95, 8'h05, 8'hA0}, '{8'h97, 8'hFF, 8'h3F},
    '{8'h96, 8'h05, 8'h45}, '{8'h96, 8'h3F, 8'h7F}, '{8'h90, 8'h12, 8'h00}};
  always #2 ref_clk = ~ref_clk;
  cfa_flash_crc dut_u (.ref_clk(ref_clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata),
    .cpu_halt(cpu_halt), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .crc_byte(crc_byte), .crc_init(crc_init), .crc_init_ones(crc_init_ones));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk);
    req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // flash model and crc feed monitor
  // ---------------------------------------------------------------
  // flash answers with an address-derived byte
  always @(negedge ref_clk)
    if (flash_rd)
      flash_rdata <= flash_addr[7:0] ^ flash_addr[14:7];
  always @(negedge ref_clk)
    if (crc_byte.valid === 1'b1)
    begin
      chk(crc_byte.data, exp_a[7:0] ^ exp_a[14:7]);
      exp_a <= exp_a + 15'd1;
      nbytes <= nbytes + 1;
    end
  // watchdog well beyond the expected run
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    rd(8'h95, d);
    chk(d, 8'h00);
    rd(8'h96, d);
    chk(d, 8'h40);
    rd(8'h97, d);
    chk(d, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    $display("test registers done");
    wr(8'h92, 8'h0C);
    chk({6'h00, crc_init, crc_init_ones}, 8'h03);
    wr(8'h92, 8'h08);
    chk({6'h00, crc_init, crc_init_ones}, 8'h02 ^ 8'h00);
    $display("test init done");
    wr(8'h96, 8'h82);
    wr(8'h97, 8'h00);
    wr(8'h92, 8'h00);
    chk({7'h00, cpu_halt}, 8'h01 ^ 8'h01);
    wr(8'h97, 8'h01);
    exp_a = 15'd1024;
    wr(8'h92, 8'h00);
    chk({7'h00, cpu_halt}, 8'h01);
    wr(8'h92, 8'h00);
    for (int i = 0; i < 3000 && cpu_halt === 1'b1; i++)
      @(negedge ref_clk);
    chk({7'h00, cpu_halt}, 8'h00);
    rd(8'h96, d);
    chk(d, 8'hC2);
    chk(8'(nbytes >> 2), 8'h80);
    chk(8'(nbytes), 8'h00);
    $display("test auto run done");
    exp_a = 15'h0000;
    wr(8'h96, 8'h80);
    wr(8'h92, 8'h00);
    repeat (20) @(negedge ref_clk);
    rstn = 1'b0;
    @(negedge ref_clk);
    chk({6'h00, cpu_halt, crc_byte.valid}, 8'h00);
    @(negedge ref_clk);
    rstn = 1'b1;
    rd(8'h96, d);
    chk(d, 8'h40);
    rd(8'h97, d);
    chk(d, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
